// file: core/tcm_align_hunter.sv
`timescale 1ns/1ps
`default_nettype none

module tcm_align_hunter (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  input  wire logic rx_pos_i,
  input  wire logic rx_neg_i,
  input  wire logic sample_tick_i,
  output logic      aligned_o,
  output logic      sync_hit_o
);

  logic [1:0] meta_q;
  logic [1:0] sync_q;
  logic [7:0] shift_q, shift_d;
  logic [9:0] since_q, since_d;
  logic [1:0] hits_q, hits_d;
  logic       aligned_q, aligned_d;
  logic       hit_q, hit_d;
  logic       found;
  logic       expected;

  always_comb begin
    shift_d   = shift_q;
    since_d   = since_q;
    hits_d    = hits_q;
    hit_d     = 1'b0;
    found     = 1'b0;
    expected  = 1'b0;
    if (sample_tick_i) begin
      shift_d  = {shift_q[6:0], |sync_q};
      found    = (shift_d & tcm_framer_pkg::SYNC_MASK) ==
                 tcm_framer_pkg::SYNC_PATTERN;
      expected = (since_q + 10'h001) == tcm_framer_pkg::PERIOD_BITS;
      since_d  = (since_q == 10'h3ff) ? since_q : since_q + 10'h001;
      // once counting, only the expected position may confirm the hunt
      if (hits_q == 2'h0) begin
        if (found) begin
          hits_d  = 2'h1;
          since_d = 10'h000;
          hit_d   = 1'b1;
        end
      end else if (expected) begin
        since_d = 10'h000;
        if (found) begin
          hit_d  = 1'b1;
          hits_d = (hits_q == tcm_framer_pkg::ALIGN_HITS) ? hits_q
                                                         : hits_q + 2'h1;
        end else begin
          hits_d = 2'h0;
        end
      end
    end
    aligned_d = (hits_d == tcm_framer_pkg::ALIGN_HITS);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      meta_q    <= 2'h0;
      sync_q    <= 2'h0;
      shift_q   <= 8'h00;
      since_q   <= 10'h000;
      hits_q    <= 2'h0;
      aligned_q <= 1'b0;
      hit_q     <= 1'b0;
    end else begin
      meta_q    <= {rx_pos_i, rx_neg_i};
      sync_q    <= meta_q;
      shift_q   <= shift_d;
      since_q   <= since_d;
      hits_q    <= hits_d;
      aligned_q <= aligned_d;
      hit_q     <= hit_d;
    end
  end

  assign aligned_o  = aligned_q;
  assign sync_hit_o = hit_q;

endmodule

`default_nettype wire

// file: core/tcm_burst_line_framer.sv
`timescale 1ns/1ps
`default_nettype none

module tcm_burst_line_framer (
  input  wire logic       clk_sys_i,
  input  wire logic       resetn_i,
  input  wire logic [3:0] ctrl_bits_i,
  input  wire logic       mframe_bit_i,
  input  wire logic [2:0] crc_bits_i,
  input  wire logic [7:0] b1_data_i,
  input  wire logic [7:0] b2_data_i,
  input  wire logic [1:0] d_data_i,
  input  wire logic       rx_pos_i,
  input  wire logic       rx_neg_i,
  output logic            line_pos_o,
  output logic            line_neg_o,
  output logic            line_drive_o,
  output logic            frame_start_o,
  output logic            ovh_req_o,
  output logic            slot_req_o,
  output logic [4:0]      slot_idx_o,
  output logic [9:0]      bit_pos_o,
  output logic            rx_aligned_o,
  output logic            rx_sync_hit_o
);

  // bit timer
  logic [13:0] acc_q, acc_d;
  logic [13:0] acc_sum;
  logic        bit_tick;
  logic        half_tick;

  // frame state
  logic [9:0]  pos_q, pos_d;
  logic [4:0]  slot_q, slot_d;
  logic [4:0]  off_q, off_d;
  logic [17:0] sh_q, sh_d;
  logic        mark_q, mark_d;
  logic        parity_q, parity_d;
  logic        pol_q, pol_d;

  // outputs
  logic        line_pos_q, line_pos_d;
  logic        line_neg_q, line_neg_d;
  logic        drive_q, drive_d;
  logic        fstart_q, fstart_d;
  logic        ovh_req_q, ovh_req_d;
  logic        slot_req_q, slot_req_d;
  logic [4:0]  slot_idx_q, slot_idx_d;

  // helpers
  logic        tx_bit;
  logic        burst;
  logic        in_data;
  logic [7:0]  sync_word;
  logic [17:0] slot_word;
  logic [17:0] ovh_word;

  // fractional accumulator: 312 or 313 clocks per bit, 312.5 on average,
  // so the period of 800 bits lands exactly on 250000 clocks
  always_comb begin
    acc_sum   = acc_q + tcm_framer_pkg::ACC_INC;
    bit_tick  = acc_sum >= tcm_framer_pkg::ACC_MOD;
    acc_d     = bit_tick ? acc_sum - tcm_framer_pkg::ACC_MOD : acc_sum;
    half_tick = (acc_q < tcm_framer_pkg::ACC_HALF) &&
                (acc_sum >= tcm_framer_pkg::ACC_HALF);
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      acc_q <= 14'h0000;
    end else begin
      acc_q <= acc_d;
    end
  end

  // words loaded into the shift register, first bit in the msb
  always_comb begin
    sync_word = tcm_framer_pkg::SYNC_PATTERN;
    sync_word[tcm_framer_pkg::SYNC_MARK_BIT] = ~mark_q;
    ovh_word  = {sync_word,
                 ctrl_bits_i[0],
                 mframe_bit_i,
                 ctrl_bits_i[3:1],
                 crc_bits_i,
                 2'b00};
    slot_word = {b1_data_i,
                 d_data_i[1],
                 b2_data_i,
                 d_data_i[0]};
  end

  always_comb begin
    pos_d      = pos_q;
    slot_d     = slot_q;
    off_d      = off_q;
    sh_d       = sh_q;
    mark_d     = mark_q;
    parity_d   = parity_q;
    pol_d      = pol_q;
    line_pos_d = line_pos_q;
    line_neg_d = line_neg_q;
    drive_d    = drive_q;
    slot_idx_d = slot_idx_q;
    fstart_d   = 1'b0;
    ovh_req_d  = 1'b0;
    slot_req_d = 1'b0;
    tx_bit     = 1'b0;
    burst      = 1'b0;
    in_data    = 1'b0;
    if (bit_tick) begin
      pos_d = (pos_q == tcm_framer_pkg::PERIOD_BITS) ?
              tcm_framer_pkg::FIRST_POS : pos_q + 10'h001;
      in_data = (pos_d >= tcm_framer_pkg::SLOT_FIRST) &&
                (pos_d <= tcm_framer_pkg::LAST_DATA);

      // field selection
      if (pos_d == tcm_framer_pkg::FIRST_POS) begin
        mark_d   = ~mark_q;
        sh_d     = ovh_word;
        fstart_d = 1'b1;
      end else if (pos_d == tcm_framer_pkg::SLOT_FIRST) begin
        slot_d = 5'h00;
        off_d  = 5'h00;
        sh_d   = slot_word;
      end else if (in_data) begin
        if (off_q == tcm_framer_pkg::OFF_LAST) begin
          off_d  = 5'h00;
          slot_d = slot_q + 5'h01;
          sh_d   = slot_word;
        end else begin
          off_d = off_q + 5'h01;
          sh_d  = {sh_q[16:0], 1'b0};
        end
      end else begin
        sh_d = {sh_q[16:0], 1'b0};
      end

      // bit to send and burst window
      burst = pos_d <= tcm_framer_pkg::FRAME_BITS;
      if (pos_d <= tcm_framer_pkg::LAST_DATA) begin
        tx_bit = sh_d[17];
      end else if (pos_d == tcm_framer_pkg::PARITY_POS) begin
        tx_bit = parity_q;
      end else begin
        tx_bit = 1'b0;
      end

      // running parity over positions 1..376
      if (pos_d == tcm_framer_pkg::FIRST_POS) begin
        parity_d = tx_bit;
      end else if (pos_d <= tcm_framer_pkg::LAST_DATA) begin
        parity_d = parity_q ^ tx_bit;
      end

      // alternate mark inversion; polarity carries across frames
      line_pos_d = burst && tx_bit && !pol_q;
      line_neg_d = burst && tx_bit && pol_q;
      if (burst && tx_bit) begin
        pol_d = ~pol_q;
      end
      drive_d = burst;

      // data requests one bit ahead of the load, so users get a full
      // bit period (about 312 clocks) to settle the slot inputs
      if (pos_d == tcm_framer_pkg::PERIOD_BITS) begin
        ovh_req_d = 1'b1;
      end
      if (pos_d == tcm_framer_pkg::SLOT_PREP) begin
        slot_req_d = 1'b1;
        slot_idx_d = 5'h00;
      end else if (in_data && (off_d == tcm_framer_pkg::OFF_LAST) &&
                   (slot_d != tcm_framer_pkg::SLOT_LAST)) begin
        slot_req_d = 1'b1;
        slot_idx_d = slot_d + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      // start at the last position so the first tick opens a frame
      pos_q      <= tcm_framer_pkg::PERIOD_BITS;
      slot_q     <= 5'h00;
      off_q      <= 5'h00;
      sh_q       <= 18'h0_0000;
      mark_q     <= 1'b0;
      parity_q   <= 1'b0;
      pol_q      <= 1'b0;
      line_pos_q <= 1'b0;
      line_neg_q <= 1'b0;
      drive_q    <= 1'b0;
      fstart_q   <= 1'b0;
      ovh_req_q  <= 1'b0;
      slot_req_q <= 1'b0;
      slot_idx_q <= 5'h00;
    end else begin
      pos_q      <= pos_d;
      slot_q     <= slot_d;
      off_q      <= off_d;
      sh_q       <= sh_d;
      mark_q     <= mark_d;
      parity_q   <= parity_d;
      pol_q      <= pol_d;
      line_pos_q <= line_pos_d;
      line_neg_q <= line_neg_d;
      drive_q    <= drive_d;
      fstart_q   <= fstart_d;
      ovh_req_q  <= ovh_req_d;
      slot_req_q <= slot_req_d;
      slot_idx_q <= slot_idx_d;
    end
  end

  // receive hunt samples mid-bit on the local bit timing; no clock
  // recovery, so it only suits a line with a shared bit clock
  tcm_align_hunter u_hunter (
    .clk_sys_i     (clk_sys_i),
    .resetn_i      (resetn_i),
    .rx_pos_i      (rx_pos_i),
    .rx_neg_i      (rx_neg_i),
    .sample_tick_i (half_tick),
    .aligned_o     (rx_aligned_o),
    .sync_hit_o    (rx_sync_hit_o)
  );

  assign line_pos_o    = line_pos_q;
  assign line_neg_o    = line_neg_q;
  assign line_drive_o  = drive_q;
  assign frame_start_o = fstart_q;
  assign ovh_req_o     = ovh_req_q;
  assign slot_req_o    = slot_req_q;
  assign slot_idx_o    = slot_idx_q;
  assign bit_pos_o     = pos_q;

endmodule

`default_nettype wire

// file: core/tcm_framer_pkg.sv
package tcm_framer_pkg;

  // clock and symbol rate
  localparam int unsigned CLK_HZ    = 100_000_000;
  localparam int unsigned BAUD_HZ   = 320_000;
  // both rates share this factor, so the bit timer works in small integers
  localparam int unsigned ACC_SCALE = 10_000;
  localparam logic [13:0] ACC_MOD   = 14'(CLK_HZ / ACC_SCALE);
  localparam logic [13:0] ACC_INC   = 14'(BAUD_HZ / ACC_SCALE);
  localparam logic [13:0] ACC_HALF  = 14'(CLK_HZ / ACC_SCALE / 2);

  // times in their own unit
  localparam int unsigned PERIOD_US   = 2500;
  localparam int unsigned FRAME_US_X1000 = 1_178_000;

  // bit positions within one repetition period
  localparam int unsigned POS_W       = 10;
  localparam logic [9:0]  PERIOD_BITS = 10'(PERIOD_US * (BAUD_HZ / 1000) / 1000);
  localparam logic [9:0]  FIRST_POS   = 10'h001;
  localparam logic [9:0]  SLOT_FIRST  = 10'h011;
  localparam logic [9:0]  SLOT_PREP   = 10'h010;
  localparam logic [9:0]  LAST_DATA   = 10'h178;
  localparam logic [9:0]  PARITY_POS  = 10'h179;
  localparam logic [9:0]  FRAME_BITS  = 10'h179;

  // slot layout
  localparam int unsigned SLOTS       = 20;
  localparam int unsigned SLOT_BITS   = 18;
  localparam logic [4:0]  SLOT_LAST   = 5'(SLOTS - 1);
  localparam logic [4:0]  OFF_LAST    = 5'(SLOT_BITS - 1);

  // sync pattern, first bit sent in the msb; marker sits at bit 1
  localparam logic [7:0]  SYNC_PATTERN = 8'h80;
  localparam logic [7:0]  SYNC_MASK    = 8'hfd;
  localparam int unsigned SYNC_MARK_BIT = 1;
  localparam logic [1:0]  ALIGN_HITS   = 2'h3;

endpackage

// file: verif/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic       clk_sys_i = 0, resetn_i = 0, mframe_bit_i = 1;
  logic [3:0] ctrl_bits_i = 4'hA;
  logic [2:0] crc_bits_i = 3'h3;
  logic [7:0] b1_data_i = 8'h00, b2_data_i = 8'h00;
  logic [1:0] d_data_i = 2'h0;
  logic       rx_pos_i, rx_neg_i, line_pos_o, line_neg_o, line_drive_o;
  logic       frame_start_o, ovh_req_o, slot_req_o, rx_aligned_o;
  logic       rx_sync_hit_o, mark, m2, last_neg = 1, p;
  logic [4:0] slot_idx_o;
  logic [9:0] bit_pos_o, cur_pos = 10'h320;
  logic [7:0] b;
  logic       bits1 [1:800];
  int         mismatches, tests_run, frame_no, ami_bad, silent_bad;
  int         drive_bits, hits, cyc, fs_n, fs0, fs1;
  localparam logic [10:0] rows [16] = '{
    {10'h001, 1'b1}, {10'h002, 1'b0}, {10'h003, 1'b0}, {10'h004, 1'b0},
    {10'h005, 1'b0}, {10'h006, 1'b0}, {10'h007, 1'b1}, {10'h008, 1'b0},
    {10'h009, 1'b0}, {10'h00a, 1'b1}, {10'h00b, 1'b1}, {10'h00c, 1'b0},
    {10'h00d, 1'b1}, {10'h00e, 1'b0}, {10'h00f, 1'b1}, {10'h010, 1'b1}};
  always #5 clk_sys_i = ~clk_sys_i;
  tcm_burst_line_framer dut_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .ctrl_bits_i(ctrl_bits_i), .mframe_bit_i(mframe_bit_i),
    .crc_bits_i(crc_bits_i), .b1_data_i(b1_data_i), .b2_data_i(b2_data_i),
    .d_data_i(d_data_i), .rx_pos_i(rx_pos_i), .rx_neg_i(rx_neg_i),
    .line_pos_o(line_pos_o), .line_neg_o(line_neg_o),
    .line_drive_o(line_drive_o), .frame_start_o(frame_start_o),
    .ovh_req_o(ovh_req_o), .slot_req_o(slot_req_o), .slot_idx_o(slot_idx_o),
    .bit_pos_o(bit_pos_o), .rx_aligned_o(rx_aligned_o),
    .rx_sync_hit_o(rx_sync_hit_o));
  tcm_far_end far_u (.clk_sys_i(clk_sys_i), .resetn_i(resetn_i),
    .rx_pos_o(rx_pos_i), .rx_neg_o(rx_neg_i));
  always @(negedge clk_sys_i) begin
    if (slot_req_o === 1'b1) begin
      b1_data_i <= {slot_idx_o, 3'h5};
      b2_data_i <= ~{slot_idx_o, 3'h5};
      d_data_i <= {slot_idx_o[0], ~slot_idx_o[0]};
    end
  end
  always @(posedge clk_sys_i) begin
    cyc++;
    if (rx_sync_hit_o === 1'b1) hits++;
    if (frame_start_o === 1'b1) begin
      fs0 = fs1;
      fs1 = cyc;
      fs_n++;
    end
  end
  // sample mid-bit, well clear of the one-clock output lag
  always begin
    @(posedge clk_sys_i);
    if (bit_pos_o !== cur_pos) begin
      cur_pos = bit_pos_o;
      repeat (150) @(posedge clk_sys_i);
      mark = line_pos_o | line_neg_o;
      if (cur_pos == 10'h001) frame_no++;
      if ((line_pos_o && !last_neg) || (line_neg_o && last_neg)) ami_bad++;
      if (line_pos_o) last_neg = 0;
      if (line_neg_o) last_neg = 1;
      if (frame_no == 1) bits1[cur_pos] = mark;
      if (frame_no == 1 && line_drive_o && cur_pos <= 10'h179) drive_bits++;
      if (frame_no == 2 && cur_pos == 10'h007) m2 = mark;
      if (cur_pos > 10'h179 && (mark || line_drive_o)) silent_bad++;
    end
  end
  task automatic chk(input logic got, input logic exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkv(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // one period is 250000 clocks and has no shortening parameter
  initial begin
    #4_000_000;
    mismatches++;
    print_verdict;
  end
  initial begin
    repeat (2) @(negedge clk_sys_i);
    chkv(bit_pos_o, 10'h320);
    chk(line_drive_o, 1'b0);
    @(negedge clk_sys_i);
    resetn_i = 1;
    wait (frame_no == 2 && cur_pos == 10'h009);
    @(negedge clk_sys_i);
    for (int i = 0; i < 16; i++) chk(bits1[rows[i][10:1]], rows[i][0]);
    $display("test header done");
    for (int n = 0; n < 20; n++) begin
      b = {n[4:0], 3'h5};
      for (int k = 0; k < 8; k++) begin
        chk(bits1[17 + 18 * n + k], b[7 - k]);
        chk(bits1[26 + 18 * n + k], ~b[7 - k]);
      end
      chk(bits1[25 + 18 * n], n[0]);
      chk(bits1[34 + 18 * n], ~n[0]);
    end
    $display("test slots done");
    p = 0;
    for (int i = 1; i < 377; i++) p ^= bits1[i];
    chk(bits1[377], p);
    chkv(ami_bad, 0);
    chkv(silent_bad, 0);
    chkv(drive_bits, 377);
    chk(m2, 1'b0);
    chkv(fs1 - fs0, 250000);
    chkv(hits, 2);
    chk(rx_aligned_o, 1'b0);
    $display("test timing done");
    print_verdict;
  end
endmodule
`default_nettype wire

// file: verif/tcm_far_end.sv
`timescale 1ns/1ps
`default_nettype none
module tcm_far_end (
  input  wire logic clk_sys_i,
  input  wire logic resetn_i,
  output logic      rx_pos_o,
  output logic      rx_neg_o
);
  logic [13:0] acc_q;
  logic [9:0]  bit_q;
  logic        neg_q;
  logic        mrk_q;
  // return burst holds only the sync word; other bits are ami zeros
  always @(posedge clk_sys_i or negedge resetn_i) begin
    logic [9:0] nb;
    logic [7:0] w;
    logic       m;
    nb = (bit_q == 10'h320) ? 10'h001 : bit_q + 10'h001;
    w = {6'h20, mrk_q, 1'b0};
    m = (nb <= 10'h008) && w[3'(10'h008 - nb)];
    if (!resetn_i) begin
      acc_q <= 14'h0000;
      bit_q <= 10'h320;
      neg_q <= 1'b1;
      mrk_q <= 1'b1;
      rx_pos_o <= 1'b0;
      rx_neg_o <= 1'b0;
    end else if (acc_q + tcm_framer_pkg::ACC_INC >= tcm_framer_pkg::ACC_MOD) begin
      acc_q <= acc_q + tcm_framer_pkg::ACC_INC - tcm_framer_pkg::ACC_MOD;
      bit_q <= nb;
      rx_pos_o <= m & neg_q;
      rx_neg_o <= m & ~neg_q;
      if (m) neg_q <= ~neg_q;
      if (nb == 10'h008) mrk_q <= ~mrk_q;
    end else begin
      acc_q <= acc_q + tcm_framer_pkg::ACC_INC;
    end
  end
endmodule
`default_nettype wire

// file: verif/tcm_framer_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module tcm_framer_monitor (
  input wire logic       clk_sys_i,
  input wire logic       resetn_i,
  input wire logic       line_pos_o,
  input wire logic       line_neg_o,
  input wire logic       line_drive_o,
  input wire logic       frame_start_o,
  input wire logic       ovh_req_o,
  input wire logic [9:0] bit_pos_o,
  input wire logic       rx_sync_hit_o
);
  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!resetn_i);
  logic       neg_last_q, neg_last_d, seen_q, seen_d;
  logic [9:0] prev_q, cnt_q, cnt_d;
  always_comb begin
    neg_last_d = line_pos_o ? 1'b0 : (line_neg_o ? 1'b1 : neg_last_q);
    seen_d = seen_q | (bit_pos_o != prev_q);
    cnt_d = (bit_pos_o != prev_q) ? 10'h000 : cnt_q + 10'h001;
  end
  // first bit after reset is timed from release, so it is not measured
  always_ff @(posedge clk_sys_i or negedge resetn_i) begin
    if (!resetn_i) begin
      neg_last_q <= 1'b1;
      seen_q <= 1'b0;
      prev_q <= 10'h320;
      cnt_q <= 10'h000;
    end else begin
      neg_last_q <= neg_last_d;
      seen_q <= seen_d;
      prev_q <= bit_pos_o;
      cnt_q <= cnt_d;
    end
  end
  sequence s_burst_on;
    line_drive_o && (line_pos_o || line_neg_o) ##1 !frame_start_o;
  endsequence
  a_no_dual_pulse: assert property (!(line_pos_o && line_neg_o))
    else $error("both line polarities driven");
  a_ami_alternate: assert property ($rose(line_pos_o) || $rose(line_neg_o)
    |-> line_pos_o == neg_last_q) else $error("mark polarity repeated");
  a_bit_length: assert property (seen_q && bit_pos_o != prev_q
    |-> cnt_q inside {10'h137, 10'h138}) else $error("bit length wrong");
  a_drive_window: assert property (line_drive_o
    |-> bit_pos_o inside {[10'h001:10'h179]}) else $error("drive outside burst");
  a_gap_window: assert property (!line_drive_o |-> bit_pos_o >= 10'h17a)
    else $error("burst dropped early");
  a_silent_gap: assert property (!line_drive_o
    |-> !line_pos_o && !line_neg_o) else $error("pulse while silent");
  a_burst_begin: assert property (frame_start_o
    |-> bit_pos_o == 10'h001 ##0 s_burst_on) else $error("bad frame start");
  a_pos_step: assert property (bit_pos_o != prev_q |-> bit_pos_o ==
    ((prev_q == 10'h320) ? 10'h001 : prev_q + 10'h001))
    else $error("position skipped");
  a_ovh_request: assert property (ovh_req_o
    |-> bit_pos_o == 10'h320) else $error("overhead request misplaced");
  a_hit_pulse: assert property (rx_sync_hit_o |=> !rx_sync_hit_o)
    else $error("sync hit longer than one clock");
endmodule
bind tcm_burst_line_framer tcm_framer_monitor mon_u (.*);
`default_nettype wire
